// [pkg/synth_latch_defs.svh]
/*
 * Holds bit positions, selector codes and widths of the programming latches.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef SYNTH_LATCH_DEFS_SVH
`define SYNTH_LATCH_DEFS_SVH

`define WORD_W          24
`define CNT_W           5
`define SEL_CONTROL     2'h0
`define SEL_REFERENCE   2'h1
`define SEL_FEEDBACK    2'h2
`define SEL_TEST        2'h3
// control latch fields
`define CTL_CORE_LO     2
`define CTL_CLEAR       4
`define CTL_MUX_LO      5
`define CTL_POL         8
`define CTL_TRI         9
`define CTL_GAIN        10
`define CTL_MUTE        11
`define CTL_LEVEL_LO    12
`define CTL_CURA_LO     14
`define CTL_CURB_LO     17
`define CTL_PDEN        20
`define CTL_PDSYNC      21
`define CTL_MOD_LO      22
// reference latch fields
`define REF_DIV_LO      2
`define REF_ABP_LO      16
`define REF_LDP         18
`define REF_TMB         19
`define REF_BSC_LO      20
// feedback latch fields
`define FB_SWALLOW_LO   2
`define FB_RSV          7
`define FB_MAIN_LO      8
`define FB_GAIN         21
`define FB_HALVE_EN     22
`define FB_HALVE_SEL    23
// reset values of the latches
`define WORD_RESET      24'h000000
// powerdown sync: edges of reference divider output after strobe
`define SYNC_EDGES      2'h2

`endif

// [pkg/synth_latch_pkg.sv]
/*
 * Types shared by the latch bank and its serial front end.
 * Assumes the defines header is on the include path.
 */
package synth_latch_pkg;
    `include "synth_latch_defs.svh"

    typedef enum logic [1:0] {
        MOD_8_9   = 2'h0,
        MOD_16_17 = 2'h1,
        MOD_32_33 = 2'h2
    } modulus_t;

    typedef enum logic [2:0] {
        PD_RUN  = 3'h1,
        PD_WAIT = 3'h2,
        PD_DOWN = 3'h4
    } pd_state_t;

    typedef logic [`WORD_W-1:0] word_t;
endpackage : synth_latch_pkg

// [pkg/serial_word_if.sv]
/*
 * Carries a completed serial word from the front end to the latch bank.
 * Assumes both ends share clk_sys.
 */
interface serial_word_if;
    import synth_latch_pkg::*;
    word_t word;
    logic  wordStrobe;
    modport front (output word, output wordStrobe);
    modport bank  (input  word, input  wordStrobe);
endinterface : serial_word_if

// [hw/serial_front.sv]
/*
 * Synchronises the three serial pins and shifts the word in.
 * Assumes pins are asynchronous to clk_sys and slow against it.
 */
`include "synth_latch_defs.svh"
module serial_front
    import synth_latch_pkg::*;
(
    // clock and reset
    input  wire logic  clk_sys,
    input  wire logic  srst,
    // serial pins
    input  wire logic  serialClk,
    input  wire logic  serialData,
    input  wire logic  loadStrobe,
    // word out
    serial_word_if.front wordOut
);
    import synth_latch_pkg::*;

    logic [2:0] clkSync_ff;
    logic [2:0] datSync_ff;
    logic [2:0] leSync_ff;
    logic       clkLvl_ff;
    logic       leLvl_ff;
    word_t      shift_ff;
    logic       strobe_ff;
    logic [2:0] nxt_clkSync;
    logic [2:0] nxt_datSync;
    logic [2:0] nxt_leSync;
    logic       nxt_clkLvl;
    logic       nxt_leLvl;
    word_t      nxt_shift;
    logic       nxt_strobe;

    // a change counts once the second and third stages agree
    always_comb begin
        nxt_clkSync = {clkSync_ff[1:0], serialClk};
        nxt_datSync = {datSync_ff[1:0], serialData};
        nxt_leSync  = {leSync_ff[1:0], loadStrobe};
        nxt_clkLvl  = clkLvl_ff;
        nxt_leLvl   = leLvl_ff;
        nxt_shift   = shift_ff;
        nxt_strobe  = 1'b0;
        if (clkSync_ff[1] == clkSync_ff[2]) begin
            nxt_clkLvl = clkSync_ff[2];
        end
        if (leSync_ff[1] == leSync_ff[2]) begin
            nxt_leLvl = leSync_ff[2];
        end
        if (nxt_clkLvl && !clkLvl_ff) begin
            nxt_shift = {shift_ff[`WORD_W-2:0], datSync_ff[2]};
        end
        if (nxt_leLvl && !leLvl_ff) begin
            nxt_strobe = 1'b1;
        end
    end

    // register stage; shifting keeps going in powerdown
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            clkSync_ff <= 3'h0;
            datSync_ff <= 3'h0;
            leSync_ff  <= 3'h0;
            clkLvl_ff  <= 1'b0;
            leLvl_ff   <= 1'b0;
            shift_ff   <= `WORD_RESET;
            strobe_ff  <= 1'b0;
        end else begin
            clkSync_ff <= nxt_clkSync;
            datSync_ff <= nxt_datSync;
            leSync_ff  <= nxt_leSync;
            clkLvl_ff  <= nxt_clkLvl;
            leLvl_ff   <= nxt_leLvl;
            shift_ff   <= nxt_shift;
            strobe_ff  <= nxt_strobe;
        end
    end

    assign wordOut.word       = shift_ff;
    assign wordOut.wordStrobe = strobe_ff;
endmodule : serial_front

// [hw/synth_latch_programming.sv]
/*
 * Programming latches of an integer-N synthesizer: serial word intake,
 * latch routing, field decode and the two powerdown modes.
 * Assumes a host drives clock, data and load strobe pins; the reference
 * divider output arrives as an asynchronous pin.
 */
`include "synth_latch_defs.svh"
module synth_latch_programming
    import synth_latch_pkg::*;
(
    // clock and reset
    input  wire logic  clk_sys,
    input  wire logic  srst,
    // serial programming pins
    input  wire logic  serialClk,
    input  wire logic  serialData,
    input  wire logic  loadStrobe,
    // reference divider output, timing source for synchronous powerdown
    input  wire logic  refDivOut,
    // decoded control fields
    output synth_latch_pkg::modulus_t modulus,
    output logic [1:0] coreLevel,
    output logic       dividerClear,
    output logic [2:0] outmuxSel,
    output logic       detectorPolarity,
    output logic       pumpGainSelect,
    output logic       muteUntilLocked,
    output logic [1:0] outputLevel,
    output logic [2:0] pumpCurrentA,
    output logic [2:0] pumpCurrentB,
    // decoded reference fields
    output logic [13:0] refDivide,
    output logic [1:0] backlashWidth,
    output logic       lockPrecision,
    output logic       testBit,
    output logic [1:0] bandClockDiv,
    // decoded feedback fields
    output logic [4:0] swallowCount,
    output logic [12:0] mainCount,
    output logic       fbPumpGain,
    output logic       halveOutputEnable,
    output logic       halveOutputSelect,
    output logic       bandSelectStart,
    // powerdown effects
    output logic       poweredDown,
    output logic       countersLoadState,
    output logic       pumpTristate,
    output logic       lockDetectReset,
    output logic       refBufferEnable,
    output logic       rfInputBiased,
    output logic       biasCurrentEnable
);
    import synth_latch_pkg::*;

    serial_word_if wordLink ();

    serial_front u_front (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .serialClk  (serialClk),
        .serialData (serialData),
        .loadStrobe (loadStrobe),
        .wordOut    (wordLink.front)
    );

    //--------------------------------------------------------------
    // reference edge detection
    //--------------------------------------------------------------
    logic [2:0] refSync_ff;
    logic       refLvl_ff;
    logic [2:0] nxt_refSync;
    logic       nxt_refLvl;
    logic       refRise;

    // three stages, then agreement of the last two
    always_comb begin
        nxt_refSync = {refSync_ff[1:0], refDivOut};
        nxt_refLvl  = refLvl_ff;
        if (refSync_ff[1] == refSync_ff[2]) begin
            nxt_refLvl = refSync_ff[2];
        end
        refRise = nxt_refLvl && !refLvl_ff;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            refSync_ff <= 3'h0;
            refLvl_ff  <= 1'b0;
        end else begin
            refSync_ff <= nxt_refSync;
            refLvl_ff  <= nxt_refLvl;
        end
    end

    //--------------------------------------------------------------
    // latches and powerdown sequencing
    //--------------------------------------------------------------
    word_t      ctl_ff;
    word_t      ref_ff;
    word_t      fb_ff;
    pd_state_t  pd_ff;
    logic [1:0] edgeCnt_ff;
    logic       bandStart_ff;
    word_t      nxt_ctl;
    word_t      nxt_ref;
    word_t      nxt_fb;
    pd_state_t  nxt_pd;
    logic [1:0] nxt_edgeCnt;
    logic       nxt_bandStart;
    logic       ctlLoad;
    logic       pdEn;
    logic       pdSync;

    always_comb begin
        nxt_ctl       = ctl_ff;
        nxt_ref       = ref_ff;
        nxt_fb        = fb_ff;
        nxt_bandStart = 1'b0;
        ctlLoad       = 1'b0;
        // route by selector; test latch code is dropped
        if (wordLink.wordStrobe) begin
            case (wordLink.word[1:0])
                `SEL_CONTROL: begin
                    nxt_ctl = wordLink.word;
                    ctlLoad = 1'b1;
                end
                `SEL_REFERENCE: nxt_ref = wordLink.word;
                `SEL_FEEDBACK: begin
                    nxt_fb        = wordLink.word;
                    nxt_bandStart = 1'b1;
                end
                default: ;
            endcase
        end
        pdEn   = nxt_ctl[`CTL_PDEN];
        pdSync = nxt_ctl[`CTL_PDSYNC];
        nxt_pd      = pd_ff;
        nxt_edgeCnt = edgeCnt_ff;
        case (pd_ff)
            PD_RUN, PD_DOWN: begin
                if (!pdEn) begin
                    nxt_pd = PD_RUN;
                end else if (ctlLoad && !pdSync) begin
                    nxt_pd = PD_DOWN;
                end else if (ctlLoad) begin
                    nxt_pd      = (pd_ff == PD_DOWN) ? PD_DOWN : PD_WAIT;
                    nxt_edgeCnt = 2'h0;
                end
            end
            PD_WAIT: begin
                if (!pdEn) begin
                    nxt_pd = PD_RUN;
                end else if (ctlLoad && !pdSync) begin
                    nxt_pd = PD_DOWN;
                end else if (ctlLoad) begin
                    nxt_edgeCnt = 2'h0;
                end else if (refRise) begin
                    nxt_edgeCnt = edgeCnt_ff + 2'h1;
                    if (edgeCnt_ff + 2'h1 == `SYNC_EDGES) begin
                        nxt_pd = PD_DOWN;
                    end
                end
            end
            default: nxt_pd = PD_RUN;
        endcase
    end

    // latching stays live whatever the powerdown state
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctl_ff       <= `WORD_RESET;
            ref_ff       <= `WORD_RESET;
            fb_ff        <= `WORD_RESET;
            pd_ff        <= PD_RUN;
            edgeCnt_ff   <= 2'h0;
            bandStart_ff <= 1'b0;
        end else begin
            ctl_ff       <= nxt_ctl;
            ref_ff       <= nxt_ref;
            fb_ff        <= nxt_fb;
            pd_ff        <= nxt_pd;
            edgeCnt_ff   <= nxt_edgeCnt;
            bandStart_ff <= nxt_bandStart;
        end
    end

    //--------------------------------------------------------------
    // field decode, straight from latch flops
    //--------------------------------------------------------------
    logic down;
    assign down = (pd_ff == PD_DOWN);

    // codes 10 and 11 both give 32/33
    assign modulus = ctl_ff[`CTL_MOD_LO+1] ? MOD_32_33 :
                     (ctl_ff[`CTL_MOD_LO] ? MOD_16_17 : MOD_8_9);
    assign coreLevel        = ctl_ff[`CTL_CORE_LO +: 2];
    assign dividerClear     = ctl_ff[`CTL_CLEAR];
    assign outmuxSel        = ctl_ff[`CTL_MUX_LO +: 3];
    assign detectorPolarity = ctl_ff[`CTL_POL];
    assign pumpGainSelect   = ctl_ff[`CTL_GAIN];
    assign muteUntilLocked  = ctl_ff[`CTL_MUTE];
    assign outputLevel      = ctl_ff[`CTL_LEVEL_LO +: 2];
    assign pumpCurrentA     = ctl_ff[`CTL_CURA_LO +: 3];
    assign pumpCurrentB     = ctl_ff[`CTL_CURB_LO +: 3];
    assign refDivide        = ref_ff[`REF_DIV_LO +: 14];
    assign backlashWidth    = ref_ff[`REF_ABP_LO +: 2];
    assign lockPrecision    = ref_ff[`REF_LDP];
    assign testBit          = ref_ff[`REF_TMB];
    assign bandClockDiv     = ref_ff[`REF_BSC_LO +: 2];
    // feedback field slices; reserved bit ignored
    assign swallowCount      = fb_ff[`FB_SWALLOW_LO +: 5];
    assign mainCount         = fb_ff[`FB_MAIN_LO +: 13];
    assign fbPumpGain        = fb_ff[`FB_GAIN];
    assign halveOutputEnable = fb_ff[`FB_HALVE_EN];
    assign halveOutputSelect = fb_ff[`FB_HALVE_SEL];
    assign bandSelectStart   = bandStart_ff;

    // powerdown effects follow the state flop; the clear and three-state bits also drive countersLoadState and pumpTristate
    assign poweredDown       = down;
    assign countersLoadState = down | ctl_ff[`CTL_CLEAR];
    assign pumpTristate      = down | ctl_ff[`CTL_TRI];
    assign lockDetectReset   = down;
    assign refBufferEnable   = !down;
    assign rfInputBiased     = !down;
    assign biasCurrentEnable = !down;
endmodule : synth_latch_programming

// [tb/host_serial_model.sv]
/*
 * Host controller model: drives the three-wire programming link.
 * Assumes the caller starts a word while clk_sys runs.
 */
module host_serial_model
    import synth_latch_pkg::*;
(
    // clock
    input  wire logic clk_sys,
    // serial pins
    output logic      serialClk,
    output logic      serialData,
    output logic      loadStrobe
);
    timeunit 1ns;
    timeprecision 1ps;

    // link idles with clock and strobe low
    initial begin
        serialClk = 1'b0;
        serialData = 1'b0;
        loadStrobe = 1'b0;
    end

    // six cycles per level beats the four-cycle pin filter
    task automatic hold;
        repeat (6) @(posedge clk_sys);
    endtask : hold

    task automatic send(input word_t w);
        @(posedge clk_sys);
        for (int i = $bits(w) - 1; i >= 0; i--) begin
            serialData <= w[i];
            hold();
            serialClk <= 1'b1;
            hold();
            serialClk <= 1'b0;
        end
        hold();
        loadStrobe <= 1'b1;
        hold();
        loadStrobe <= 1'b0;
        // released data line must not keep the last bit
        serialData <= ~w[0];
        hold();
    endtask : send
endmodule : host_serial_model

// [tb/synth_latch_programming_asserts.sv]
/*
 * Checker on the latch bank ports.
 * Assumes a single clk_sys domain and srst synchronous.
 */
module synth_latch_programming_asserts
    import synth_latch_pkg::*;
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        srst,
    // pins
    input wire logic        loadStrobe,
    input wire logic        refDivOut,
    // outputs
    input wire modulus_t    modulus,
    input wire logic [13:0] refDivide,
    input wire logic [12:0] mainCount,
    input wire logic        bandSelectStart,
    input wire logic        poweredDown,
    input wire logic        countersLoadState,
    input wire logic        pumpTristate,
    input wire logic        lockDetectReset,
    input wire logic        refBufferEnable,
    input wire logic        rfInputBiased,
    input wire logic        biasCurrentEnable
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    // ----------------------------------------
    // age of last pin edge, saturating
    // ----------------------------------------
    logic       ldPrev_ff;
    logic       refPrev_ff;
    logic [3:0] stbAge_ff;
    logic [3:0] causeAge_ff;
    logic [3:0] nxt_stbAge;
    logic [3:0] nxt_causeAge;

    // saturate so an old edge never looks recent again
    always_comb begin
        nxt_stbAge = stbAge_ff + {3'h0, stbAge_ff != 4'hF};
        nxt_causeAge = causeAge_ff + {3'h0, causeAge_ff != 4'hF};
        if (loadStrobe && !ldPrev_ff) begin
            nxt_stbAge = 4'h0;
        end
        if ((loadStrobe && !ldPrev_ff) || (refDivOut && !refPrev_ff)) begin
            nxt_causeAge = 4'h0;
        end
    end

    // register the ages
    always_ff @(posedge clk_sys) begin
        ldPrev_ff <= loadStrobe;
        refPrev_ff <= refDivOut;
        stbAge_ff <= srst ? 4'hF : nxt_stbAge;
        causeAge_ff <= srst ? 4'hF : nxt_causeAge;
    end

    sequence s_pd_entry;
        $rose(poweredDown);
    endsequence

    sequence s_latch_change;
        $changed(refDivide) || $changed(mainCount);
    endsequence

    a_tri_when_down: assert property (
        poweredDown |-> pumpTristate)
        else $error("pump not three-state in powerdown");
    a_load_when_down: assert property (
        poweredDown |-> countersLoadState)
        else $error("counters not held in powerdown");
    a_lock_when_down: assert property (
        poweredDown |-> lockDetectReset)
        else $error("lock detect not reset in powerdown");
    a_analog_off: assert property (
        poweredDown |->
        !(refBufferEnable || rfInputBiased || biasCurrentEnable))
        else $error("analog paths alive in powerdown");
    a_analog_on: assert property (
        !poweredDown |->
        refBufferEnable && rfInputBiased && biasCurrentEnable)
        else $error("analog paths off while running");
    a_modulus_legal: assert property (
        modulus inside {MOD_8_9, MOD_16_17, MOD_32_33})
        else $error("illegal modulus code");
    a_pd_has_cause: assert property (
        s_pd_entry |-> causeAge_ff < 4'hC)
        else $error("powerdown without strobe or reference edge");
    a_latch_on_strobe: assert property (
        s_latch_change |-> stbAge_ff < 4'hC)
        else $error("latch changed without strobe");
    a_band_pulse: assert property (
        bandSelectStart |-> stbAge_ff < 4'hC ##1 !bandSelectStart)
        else $error("band start not a strobe pulse");
endmodule : synth_latch_programming_asserts

// [tb/testbench.sv]
/*
 * Testbench for the latch bank: words go through the host model.
 * Assumes package and interface compiled before this file.
 */
module testbench
    import synth_latch_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam word_t ctlWord = 24'h4B6D5C;
    localparam word_t refWord = 24'h3ABCD5;
    localparam word_t fbWord  = 24'hA5C37E;
    localparam word_t refWord2 = 24'h0ABCD1;

    logic clk_sys, srst, serialClk, serialData, loadStrobe, refDivOut;
    modulus_t    modulus;
    logic [1:0]  coreLevel, outputLevel, backlashWidth, bandClockDiv;
    logic [2:0]  outmuxSel, pumpCurrentA, pumpCurrentB;
    logic [13:0] refDivide;
    logic [4:0]  swallowCount;
    logic [12:0] mainCount;
    logic dividerClear, detectorPolarity, pumpGainSelect, muteUntilLocked;
    logic lockPrecision, testBit, fbPumpGain, halveOutputEnable;
    logic halveOutputSelect, bandSelectStart, poweredDown;
    logic countersLoadState, pumpTristate, lockDetectReset;
    logic refBufferEnable, rfInputBiased, biasCurrentEnable;
    logic bandSeen = 1'b0;
    int   fails = 0;
    int   n_checks = 0;
    int   cycles = 0;

    synth_latch_programming i_synth_latch_programming (.*);
    host_serial_model i_host_serial_model (.clk_sys(clk_sys),
        .serialClk(serialClk), .serialData(serialData),
        .loadStrobe(loadStrobe));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic put(input word_t w);
        i_host_serial_model.send(w);
        @(negedge clk_sys);
    endtask : put

    task automatic check_pd(input logic e);
        check(poweredDown, e);
        check(pumpTristate, e);
        check(countersLoadState, e);
        check(lockDetectReset, e);
        check({refBufferEnable, rfInputBiased, biasCurrentEnable}, {3{!e}});
    endtask : check_pd

    task automatic pulse_ref;
        @(posedge clk_sys);
        refDivOut <= 1'b1;
        repeat (8) @(posedge clk_sys);
        refDivOut <= 1'b0;
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : pulse_ref

    task automatic finish_test;
        $display("Checks %0d, errors %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    // band start pulse catcher and run ceiling
    always @(posedge clk_sys) begin
        if (bandSelectStart === 1'b1) bandSeen <= 1'b1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            finish_test();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        srst = 1'b1;
        refDivOut = 1'b0;
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        check(modulus, MOD_8_9);
        check_pd(1'b0);
        put(ctlWord);
        check({outmuxSel, dividerClear, coreLevel}, ctlWord[7:2]);
        check({detectorPolarity, pumpGainSelect},
            {ctlWord[8], ctlWord[10]});
        check({outputLevel, muteUntilLocked}, ctlWord[13:11]);
        check({pumpCurrentB, pumpCurrentA}, ctlWord[19:14]);
        check({modulus, countersLoadState}, {MOD_16_17, 1'b1});
        for (int c = 0; c < 4; c++) begin
            put({2'(c), 22'h0});
            check(modulus, 24'((c > 1) ? 2 : c));
        end
        put(refWord);
        check(refDivide, refWord[15:2]);
        check({bandClockDiv, testBit, lockPrecision, backlashWidth},
            refWord[21:16]);
        put(fbWord);
        check({swallowCount, mainCount},
            {fbWord[6:2], fbWord[20:8]});
        check({halveOutputSelect, halveOutputEnable, fbPumpGain, bandSeen},
            {fbWord[23:21], 1'b1});
        // test latch word must leave every other latch alone
        put(24'hFFFFFF);
        check({refDivide, mainCount},
            {refWord[15:2], fbWord[20:8]});
        check({modulus, outmuxSel, coreLevel}, {MOD_32_33, 5'h0});
        put(24'h200000);
        check_pd(1'b0);
        put(24'h100000);
        check_pd(1'b1);
        put(refWord2);
        check(refDivide, refWord2[15:2]);
        put(24'h000000);
        check_pd(1'b0);
        put(24'h300000);
        check_pd(1'b0);
        pulse_ref();
        check_pd(1'b0);
        pulse_ref();
        check_pd(1'b1);
        finish_test();
    end
endmodule : testbench

bind synth_latch_programming synth_latch_programming_asserts i_asserts (
    .clk_sys(clk_sys), .srst(srst), .loadStrobe(loadStrobe),
    .refDivOut(refDivOut), .modulus(modulus), .refDivide(refDivide),
    .mainCount(mainCount), .bandSelectStart(bandSelectStart),
    .poweredDown(poweredDown), .countersLoadState(countersLoadState),
    .pumpTristate(pumpTristate), .lockDetectReset(lockDetectReset),
    .refBufferEnable(refBufferEnable), .rfInputBiased(rfInputBiased),
    .biasCurrentEnable(biasCurrentEnable));
